// file: rtl/ptl_target.sv
// target end: pci target sequencing toward the local back-end
`timescale 1ns/1ps
`default_nettype none
module ptl_target
   import ptl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              ce,
   ptl_if.target                  bus,
   output logic [31:0]            local_target_address,
   output logic [CMD_W-1:0]       local_command,
   output logic                   local_is_read,
   output logic [HIT_W-1:0]       window_hit,
   output logic                   wide_transfer_indicator,
   output logic                   word_transfer_strobe,
   output logic                   upper_word_strobe,
   output logic                   lower_word_strobe,
   output logic [AD_W-1:0]        local_write_data,
   output logic [CBE_W-1:0]       local_byte_enable,
   input  wire logic              backend_ready_low,
   input  wire logic [AD_W-1:0]   local_read_data
);
   ptl_state_t       state;
   logic             is_read;
   logic             is_wide;
   logic [1:0]       rdy_hist;
   logic             xfer_done;
   logic [HIT_W-1:0] next_hit;

   // window decode, one compare per window
   genvar g;
   generate
      for (g = 0; g < HIT_W; g++) begin : g_dec
         assign next_hit[g] = ((local_target_address & BAR_MASK) == BAR_BASE[g]);
      end
   endgenerate

   assign xfer_done = !bus.irdyn && !bus.trdyn;

   // sequencing
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= PTL_IDLE;
      end else if (ce) begin
         unique case (state)
            PTL_IDLE:   if (!bus.framen) state <= PTL_DECODE;
            PTL_DECODE: state <= PTL_HIT;
            PTL_HIT:    state <= (|window_hit) ? PTL_SELECT : PTL_IDLE;
            PTL_SELECT: state <= PTL_DATA;
            PTL_DATA:   if (xfer_done) state <= PTL_DONE;
            PTL_DONE:   state <= PTL_IDLE;
            default:    state <= PTL_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         local_target_address <= 32'h0;
         local_command        <= '0;
         is_read              <= 1'b0;
         is_wide              <= 1'b0;
      end else if (ce && state == PTL_IDLE && !bus.framen) begin
         local_target_address <= bus.ad[31:0];
         local_command        <= bus.cben[CMD_W-1:0];
         is_read              <= !bus.cben[0];
         is_wide              <= !bus.req64n;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         local_is_read <= 1'b0;
      end else if (ce) begin
         local_is_read <= is_read;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wide_transfer_indicator <= 1'b1;
      end else if (ce) begin
         if (state == PTL_IDLE && !bus.framen) begin
            wide_transfer_indicator <= bus.req64n;
         end else if (state == PTL_DONE) begin
            wide_transfer_indicator <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         window_hit <= '0;
      end else if (ce) begin
         if (state == PTL_DECODE) begin
            window_hit <= next_hit;
         end else if (state == PTL_DONE) begin
            window_hit <= '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bus.devseln <= 1'b1;
         bus.ack64n  <= 1'b1;
      end else if (ce) begin
         if (state == PTL_HIT && |window_hit) begin
            bus.devseln <= 1'b0;
            bus.ack64n  <= !is_wide;
         end else if (state == PTL_DATA && xfer_done) begin
            bus.devseln <= 1'b1;
            bus.ack64n  <= 1'b1;
         end
      end
   end

   // ready history for read latency
   always_ff @(posedge clk) begin
      if (srst) begin
         rdy_hist <= 2'b00;
      end else if (ce) begin
         rdy_hist <= (state == PTL_SELECT || state == PTL_DATA) ?
                     {rdy_hist[0], !backend_ready_low} : 2'b00;
      end
   end

   // target ready
   always_ff @(posedge clk) begin
      if (srst) begin
         bus.trdyn <= 1'b1;
      end else if (ce) begin
         if (state == PTL_DATA && xfer_done) begin
            bus.trdyn <= 1'b1;
         end else if (state == PTL_SELECT || state == PTL_DATA) begin
            if (!is_read) begin
               bus.trdyn <= backend_ready_low;
            end else begin
               bus.trdyn <= !(rdy_hist[0] && !backend_ready_low);
            end
         end
      end
   end

   // read data onto ad
   always_ff @(posedge clk) begin
      if (srst) begin
         bus.ad_t    <= '0;
         bus.ad_t_oe <= 1'b0;
      end else if (ce) begin
         if (state == PTL_DATA && xfer_done) begin
            bus.ad_t_oe <= 1'b0;
         end else if (state == PTL_DATA && is_read && rdy_hist[0] && !backend_ready_low) begin
            bus.ad_t    <= local_read_data;
            bus.ad_t_oe <= 1'b1;
         end
      end
   end

   // read word strobes
   always_ff @(posedge clk) begin
      if (srst) begin
         upper_word_strobe <= 1'b1;
         lower_word_strobe <= 1'b1;
      end else if (ce) begin
         if (is_read && !backend_ready_low &&
             (state == PTL_SELECT || (state == PTL_DATA && !bus.irdyn && !xfer_done))) begin
            upper_word_strobe <= !is_wide;
            lower_word_strobe <= 1'b0;
         end else begin
            upper_word_strobe <= 1'b1;
            lower_word_strobe <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         word_transfer_strobe <= 1'b1;
         local_write_data     <= '0;
         local_byte_enable    <= '1;
      end else if (ce) begin
         word_transfer_strobe <= !(state == PTL_DATA && !is_read && xfer_done);
         if (state == PTL_DATA && !is_read && xfer_done) begin
            local_write_data  <= is_wide ? bus.ad : {32'h0, bus.ad[31:0]};
            local_byte_enable <= bus.cben;
         end
      end
   end
endmodule : ptl_target
`default_nettype wire

// file: rtl/ptl_pkg.sv
// shared constants and types for the pci target local port
package ptl_pkg;
   localparam int AD_W      = 64;
   localparam int CBE_W     = 8;
   localparam int HIT_W     = 6;
   localparam int CMD_W     = 4;
   // base address windows: base per window, one mask shared by all windows
   localparam logic [31:0] BAR_BASE [HIT_W] = '{32'h1000_0000, 32'h2000_0000, 32'h3000_0000,
                                               32'h4000_0000, 32'h5000_0000, 32'h6000_0000};
   localparam logic [31:0] BAR_MASK = 32'hf000_0000;
   // bus commands
   localparam logic [CMD_W-1:0] CMD_MEM_READ  = 4'h6;
   localparam logic [CMD_W-1:0] CMD_MEM_WRITE = 4'h7;
   // buffer depth of the host data path
   localparam int BUF_DEPTH = 2;
   typedef enum logic [2:0] {
      PTL_IDLE, PTL_DECODE, PTL_HIT, PTL_SELECT, PTL_DATA, PTL_DONE
   } ptl_state_t;
endpackage : ptl_pkg

// file: rtl/ptl_if.sv
// pci signals between the master end and the target end
`timescale 1ns/1ps
`default_nettype none
interface ptl_if;
   import ptl_pkg::*;
   logic [AD_W-1:0]  ad_m;
   logic             ad_m_oe;
   logic [AD_W-1:0]  ad_t;
   logic             ad_t_oe;
   logic [CBE_W-1:0] cben;
   logic             framen;
   logic             irdyn;
   logic             req64n;
   logic             trdyn;
   logic             devseln;
   logic             ack64n;
   logic [AD_W-1:0]  ad;
   assign ad = ad_t_oe ? ad_t : (ad_m_oe ? ad_m : '1);
   modport master (output ad_m, ad_m_oe, cben, framen, irdyn, req64n,
                   input ad, trdyn, devseln, ack64n);
   modport target (output ad_t, ad_t_oe, trdyn, devseln, ack64n,
                   input ad, cben, framen, irdyn, req64n);
endinterface : ptl_if
`default_nettype wire

// file: rtl/ptl_master.sv
// master end: issues single-phase transactions from a one-entry request register
`timescale 1ns/1ps
`default_nettype none
module ptl_master
   import ptl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              ce,
   ptl_if.master                  bus,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_read,
   input  wire logic              req_wide,
   input  wire logic [31:0]       req_addr,
   input  wire logic [AD_W-1:0]   req_wdata,
   input  wire logic [CBE_W-1:0]  req_be,
   output logic                   rsp_valid,
   input  wire logic              rsp_ready,
   output logic [AD_W-1:0]        rsp_data
);
   typedef enum logic [1:0] {PTM_IDLE, PTM_ADDR, PTM_DATA, PTM_RSP} ptl_mst_state_t;
   ptl_mst_state_t   state;
   logic             cur_read;
   logic             cur_wide;
   logic [31:0]      cur_addr;
   logic [AD_W-1:0]  cur_wdata;
   logic [CBE_W-1:0] cur_be;
   logic             take;

   assign take = ce && req_valid && req_ready;

   // hold one request; ready only when idle
   always_ff @(posedge clk) begin
      if (srst) begin
         req_ready <= 1'b0;
      end else if (ce) begin
         req_ready <= (state == PTM_IDLE) && !take;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur_read  <= 1'b0;
         cur_wide  <= 1'b0;
         cur_addr  <= 32'h0;
         cur_wdata <= '0;
         cur_be    <= '0;
      end else if (take) begin
         cur_read  <= req_read;
         cur_wide  <= req_wide;
         cur_addr  <= req_addr;
         cur_wdata <= req_wdata;
         cur_be    <= req_be;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= PTM_IDLE;
      end else if (ce) begin
         unique case (state)
            PTM_IDLE: if (take) state <= PTM_ADDR;
            PTM_ADDR: state <= PTM_DATA;
            PTM_DATA: if (!bus.trdyn) state <= cur_read ? PTM_RSP : PTM_IDLE;
            PTM_RSP:  if (rsp_ready) state <= PTM_IDLE;
         endcase
      end
   end

   // pci drive
   always_ff @(posedge clk) begin
      if (srst) begin
         bus.framen  <= 1'b1;
         bus.req64n  <= 1'b1;
         bus.irdyn   <= 1'b1;
         bus.ad_m    <= '0;
         bus.ad_m_oe <= 1'b0;
         bus.cben    <= '1;
      end else if (ce) begin
         if (take) begin
            bus.framen  <= 1'b0;
            bus.req64n  <= !req_wide;
            bus.ad_m    <= {32'h0, req_addr};
            bus.ad_m_oe <= 1'b1;
            bus.cben    <= {4'hf, req_read ? CMD_MEM_READ : CMD_MEM_WRITE};
         end else if (state == PTM_ADDR) begin
            bus.framen  <= 1'b1;
            bus.req64n  <= 1'b1;
            bus.irdyn   <= 1'b0;
            bus.ad_m    <= cur_wdata;
            bus.ad_m_oe <= !cur_read;
            bus.cben    <= cur_be;
         end else if (state == PTM_DATA && !bus.trdyn) begin
            bus.irdyn   <= 1'b1;
            bus.ad_m_oe <= 1'b0;
            bus.cben    <= '1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end else if (ce) begin
         if (state == PTM_DATA && !bus.trdyn && cur_read) begin
            rsp_valid <= 1'b1;
            rsp_data  <= cur_wide ? bus.ad : {32'h0, bus.ad[31:0]};
         end else if (rsp_ready) begin
            rsp_valid <= 1'b0;
         end
      end
   end
endmodule : ptl_master
`default_nettype wire

// file: sim/ptl_monitor.sv
// checker for the pci signals between the two ends
`timescale 1ns/1ps
`default_nettype none
module ptl_monitor
   import ptl_pkg::*;
(
   input wire logic             clk,
   input wire logic             srst,
   input wire logic [CBE_W-1:0] cben,
   input wire logic             framen,
   input wire logic             irdyn,
   input wire logic             req64n,
   input wire logic             trdyn,
   input wire logic             devseln,
   input wire logic             ack64n,
   input wire logic             ad_t_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   property p_sel;
      $fell(framen) |-> ##3 $fell(devseln);
   endproperty
   a_sel: assert property (p_sel) else $error("select not three clocks after frame");
   property p_ack;
      $fell(devseln) |-> ack64n == $past(req64n, 3);
   endproperty
   a_ack: assert property (p_ack) else $error("wide acknowledge wrong");
   property p_ack_sel;
      !ack64n |-> !devseln;
   endproperty
   a_ack_sel: assert property (p_ack_sel) else $error("acknowledge without select");
   property p_trdy_sel;
      !trdyn |-> !devseln;
   endproperty
   a_trdy_sel: assert property (p_trdy_sel) else $error("ready without select");
   property p_wr;
      $fell(framen) && cben[0] |-> ##[4:12] (!trdyn && !ad_t_oe);
   endproperty
   a_wr: assert property (p_wr) else $error("write ready missing");
   property p_rd;
      $fell(framen) && !cben[0] |-> ##[5:12] (!trdyn && ad_t_oe);
   endproperty
   a_rd: assert property (p_rd) else $error("read data not driven");
   property p_rel;
      !irdyn && !trdyn |=> trdyn && devseln && ack64n;
   endproperty
   a_rel: assert property (p_rel) else $error("no release after transfer");
   property p_quiet;
      framen && irdyn && devseln |-> trdyn;
   endproperty
   a_quiet: assert property (p_quiet) else $error("ready outside transaction");
   c_wr: cover property ($fell(framen) && cben[0]);
   c_rd: cover property ($fell(framen) && !cben[0]);
   c_wide: cover property ($fell(ack64n));
endmodule : ptl_monitor
`default_nettype wire

// file: sim/test_pci_target_local_port.sv
// bench: master end and target end joined by the pci interface
`timescale 1ns/1ps
`default_nettype none
module test_pci_target_local_port;
   import ptl_pkg::*;
   logic             clk = 1'b0;
   logic             srst = 1'b1;
   logic             req_valid = 1'b0;
   logic             req_ready;
   logic             req_read = 1'b0;
   logic [31:0]      req_addr = 32'h0;
   logic [AD_W-1:0]  req_wdata = 64'h0;
   logic             rsp_valid;
   logic             rsp_ready = 1'b0;
   logic [AD_W-1:0]  rsp_data;
   logic [31:0]      lta;
   logic [CMD_W-1:0] lcmd;
   logic [HIT_W-1:0] hit;
   logic             wide_n;
   logic             wstb;
   logic             ustb;
   logic             lstb;
   logic [AD_W-1:0]  lwd;
   logic             rdy_n = 1'b1;
   logic [AD_W-1:0]  lrd = 64'h0;
   logic             lis_rd;
   logic [CBE_W-1:0] lbe;
   logic [CBE_W-1:0] req_be = 8'h00;
   logic [AD_W-1:0]  rsp_got = 64'h0;
   int               rsp_cnt = 0;
   logic [31:0]      seed = 32'hf3b5;
   logic [31:0]      st = 32'hf3b5;
   int               fail_count = 0;
   int               n_checks = 0;
   ptl_if u_ptl_if ();
   ptl_master u_ptl_master (.clk(clk), .srst(srst), .ce(1'b1), .bus(u_ptl_if), .req_valid(req_valid),
      .req_ready(req_ready), .req_read(req_read), .req_wide(req_read), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_be(req_be), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_data(rsp_data));
   ptl_target u_ptl_target (.clk(clk), .srst(srst), .ce(1'b1), .bus(u_ptl_if), .local_target_address(lta),
      .local_command(lcmd), .local_is_read(lis_rd), .window_hit(hit), .wide_transfer_indicator(wide_n),
      .word_transfer_strobe(wstb), .upper_word_strobe(ustb), .lower_word_strobe(lstb),
      .local_write_data(lwd), .local_byte_enable(lbe), .backend_ready_low(rdy_n), .local_read_data(lrd));
   ptl_monitor u_mon (.clk(clk), .srst(srst), .cben(u_ptl_if.cben), .framen(u_ptl_if.framen),
      .irdyn(u_ptl_if.irdyn), .req64n(u_ptl_if.req64n), .trdyn(u_ptl_if.trdyn),
      .devseln(u_ptl_if.devseln), .ack64n(u_ptl_if.ack64n), .ad_t_oe(u_ptl_if.ad_t_oe));
   always #12.5 clk = ~clk;
   function automatic logic [31:0] rnd_next(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : rnd_next
   function automatic logic [HIT_W-1:0] exp_hit(input logic [31:0] a);
      return HIT_W'(1) << (a[31:28] - 4'h1);
   endfunction : exp_hit
   // stalling receiver of read responses; a response is taken when valid meets ready
   always @(negedge clk) begin
      st <= rnd_next(st);
      rsp_ready <= st[0];
      if (rsp_valid === 1'b1 && st[0]) begin
         rsp_got <= rsp_data;
         rsp_cnt <= rsp_cnt + 1;
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic hang(input int k);
      fail_count++;
      $display("BAD %0t wait %h exp %h", $time, k, 0);
      final_report();
   endtask : hang
   task automatic chk_d(input logic [AD_W-1:0] got, input logic [AD_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_d
   task automatic chk_f(input logic [31:0] got, input logic [31:0] exp);
      chk_d({32'h0, got}, {32'h0, exp});
   endtask : chk_f
   task automatic run_txn(input logic rd, input logic [31:0] a, input logic [AD_W-1:0] d, input int gap);
      int k;
      int n0;
      n0 = rsp_cnt;
      @(negedge clk);
      req_valid = 1'b1;
      req_read = rd;
      req_addr = a;
      req_wdata = d;
      req_be = d[63:56];
      lrd = d;
      for (k = 0; k < 20 && req_ready !== 1'b1; k++) @(negedge clk);
      if (req_ready !== 1'b1) hang(k);
      @(negedge clk);
      req_valid = 1'b0;
      for (k = 0; k < 20 && hit === '0; k++) @(negedge clk);
      if (hit === '0) hang(k);
      chk_f(lta, a);
      chk_f(32'(lcmd), 32'(rd ? CMD_MEM_READ : CMD_MEM_WRITE));
      chk_f(32'(lis_rd), 32'(rd));
      chk_f(32'(hit), 32'(exp_hit(a)));
      chk_f(32'(wide_n), 32'(!rd));
      repeat (gap + 1) @(negedge clk);
      rdy_n = 1'b0;
      for (k = 0; k < 20 && (rd ? lstb : wstb) !== 1'b0; k++) @(negedge clk);
      if ((rd ? lstb : wstb) !== 1'b0) hang(k);
      chk_f(32'(k), rd ? 32'h1 : 32'h2);
      if (rd) chk_f(32'(ustb), 32'h0);
      else chk_d(lwd, {32'h0, d[31:0]});
      if (!rd) chk_f(32'(lbe), 32'(d[63:56]));
      for (k = 0; k < 20 && hit !== '0; k++) @(negedge clk);
      if (hit !== '0) hang(k);
      chk_f({29'h0, wstb, ustb, lstb}, 32'h7);
      rdy_n = 1'b1;
      if (rd) begin
         for (k = 0; k < 40 && rsp_cnt == n0; k++) @(negedge clk);
         if (rsp_cnt == n0) hang(k);
         chk_d(rsp_got, d);
      end
      $display("txn read=%0d addr %h done", rd, a);
   endtask : run_txn
   initial begin
      logic [31:0] a;
      logic [31:0] d;
      repeat (5) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      run_txn(1'b0, 32'h1000_0000, '1, 0);
      run_txn(1'b1, 32'h6fff_fffc, 64'h8000_0000_0000_0001, 3);
      for (int i = 0; i < 24; i++) begin
         seed = rnd_next(seed);
         a = {4'(seed % 6) + 4'h1, seed[27:0]};
         seed = rnd_next(seed);
         d = seed;
         seed = rnd_next(seed);
         run_txn(seed[8], a, {d, seed}, int'(seed[5:4]));
      end
      final_report();
   end
endmodule : test_pci_target_local_port
`default_nettype wire
